/* File: logic/rafs_map.vh */
// named constants for the read address fifo sideband block
`ifndef RAFS_MAP_VH
`define RAFS_MAP_VH

// default geometry
`define RAFS_DEF_DEPTH      16
`define RAFS_DEF_ADDR_W     4
`define RAFS_DEF_WIDTH      32
`define RAFS_DEF_PAR_BITS   6

// fault injection bit positions inside the codeword
`define RAFS_INJ_BIT_A      3
`define RAFS_INJ_BIT_B      5

// reset values
`define RAFS_RST_FLAG       1'b0
`define RAFS_RST_LOW_FLAG   1'b1

// step of one word for the tallies
`define RAFS_ONE_WORD       1

`endif

/* File: logic/rafs_sideband.v */
// read address fifo core with threshold, ecc, refusal and tally sideband
// Function
// (R1) upper threshold input, depth log2 bits wide
// (R2) lower threshold input, same width
// (R3) thresholds captured while held in reset
// (R4) upper flag high when tally at/above upper
// (R5) lower flag high when tally at/below lower
// (R6) single inject corrupts one codeword bit
// (R7) double inject corrupts two codeword bits
// (R8) corrected error flagged alongside read word
// (R9) double error flagged as uncorrectable word
// (R10) refused write flagged one cycle, harmless
// (R11) refusal flag zero while handshake respected
// (R12) refused read flagged one cycle, harmless
// (R13) refusal flag zero while handshake respected
// (R14) write tally never below true occupancy
// (R15) write shows in write tally next edge
// (R16) read tally never above readable amount
// (R17) read shows in read tally next edge
// (R18) common stored word tally output
// (R19) reset clears flags, tallies show empty; the lower level flag is set, not cleared, at reset
`include "rafs_map.vh"
`timescale 1ns/1ns
`default_nettype none

module rafs_sideband #(
    parameter integer DEPTH    = `RAFS_DEF_DEPTH,    // words, power of two
    parameter integer ADDR_W   = `RAFS_DEF_ADDR_W,   // log2 of depth
    parameter integer WIDTH    = `RAFS_DEF_WIDTH,    // payload bits
    parameter integer PAR_BITS = `RAFS_DEF_PAR_BITS, // hamming check bits
    parameter integer ECC_EN   = 1                   // error correction used
) (
    input  wire              CLK_SYS_IN,                 // 50 MHz clock
    input  wire              RSTN_IN,                    // sync reset, low
    input  wire              WR_REQ_IN,                  // write request
    input  wire [WIDTH-1:0]  WR_DATA_IN,                 // write payload
    output wire              WR_READY_OUT,               // room for a write
    input  wire              RD_REQ_IN,                  // read request
    output reg  [WIDTH-1:0]  RD_DATA_OUT,                // read payload
    output wire              RD_VALID_OUT,               // a word to read
    input  wire [ADDR_W-1:0] UPPER_LEVEL_THRESHOLD_IN,   // upper level
    input  wire [ADDR_W-1:0] LOWER_LEVEL_THRESHOLD_IN,   // lower level
    input  wire              SINGLE_ERROR_INJECT_IN,     // flip one bit
    input  wire              DOUBLE_ERROR_INJECT_IN,     // flip two bits
    output reg               CORRECTED_ERROR_FLAG_OUT,   // one bit fixed
    output reg               UNCORRECTABLE_ERROR_FLAG_OUT, // word corrupt
    output reg               WRITE_REFUSED_FLAG_OUT,     // write refused
    output reg               READ_REFUSED_FLAG_OUT,      // read refused
    output reg  [ADDR_W+1:0] WR_WORD_TALLY_OUT,          // written words
    output reg  [ADDR_W+1:0] RD_WORD_TALLY_OUT,          // readable words
    output reg  [ADDR_W+1:0] STORED_WORD_TALLY_OUT,      // stored words
    output reg               UPPER_LEVEL_FLAG_OUT,       // at/above upper
    output reg               LOWER_LEVEL_FLAG_OUT        // at/below lower
);

    // codeword length: overall parity, check bits, payload
    localparam integer N  = WIDTH + PAR_BITS + 1;
    localparam integer CW = ADDR_W + 2;
    // one word step at tally width, no silent truncation
    localparam [CW-1:0] ONE_WORD = `RAFS_ONE_WORD;

    // codeword layout, lsb first:
    //   bit 0            overall parity over the whole word
    //   power of two     hamming check bits
    //   all other bits   payload, lowest payload bit first
    // a flip in bit 0 alone still reports as corrected
    // a double flip keeps overall parity even, syndrome non zero
    // three or more flips are not guaranteed to be spotted
    // storage keeps the codeword, decode happens on the read side

    // storage and pointers
    reg  [N-1:0]      mem_reg [0:DEPTH-1]; // codeword storage
    reg  [ADDR_W-1:0] wr_ptr_reg;          // next slot to write
    reg  [ADDR_W-1:0] rd_ptr_reg;          // next slot to read
    reg  [CW-1:0]     count_reg;           // true occupancy
    reg  [CW-1:0]     count_next;          // occupancy after this edge
    reg  [ADDR_W-1:0] upper_thr_reg;       // captured upper level
    reg  [ADDR_W-1:0] lower_thr_reg;       // captured lower level
    reg  [N-1:0]      code_w;              // codeword being written
    wire [WIDTH+1:0]  dec_rd;              // {double, single, payload}
    wire              full;                // no room left
    wire              empty;               // nothing stored
    wire              wr_take;             // write accepted
    wire              rd_take;             // read accepted

    // hamming encode with overall parity in bit 0
    function [N-1:0] ecc_encode;
        input [WIDTH-1:0] d;
        integer i;
        integer k;
        integer j;
        reg [N-1:0] c;
        begin
            c = {N{1'b0}};
            j = 0;
            // payload fills the non power of two positions
            for (i = 1; i < N; i = i + 1) begin
                if ((i & (i - 1)) != 0) begin
                    c[i] = d[j];
                    j = j + 1;
                end
            end
            // each check bit covers positions with its bit set
            for (k = 0; k < PAR_BITS; k = k + 1) begin
                for (i = 1; i < N; i = i + 1) begin
                    if ((((i >> k) & 1) == 1) && (i != (1 << k))) begin
                        c[1 << k] = c[1 << k] ^ c[i];
                    end
                end
            end
            c[0] = ^c;
            ecc_encode = c;
        end
    endfunction

    // hamming decode, repairs a single error, spots a double
    function [WIDTH+1:0] ecc_decode;
        input [N-1:0] cin;
        integer i;
        integer j;
        integer syn;
        reg [N-1:0] c;
        reg ov;
        reg sgl;
        reg dbl;
        reg [WIDTH-1:0] d;
        begin
            c = cin;
            syn = 0;
            d = {WIDTH{1'b0}};
            // syndrome is the xor of all set positions
            for (i = 1; i < N; i = i + 1) begin
                if (c[i]) begin
                    syn = syn ^ i;
                end
            end
            ov = ^c;
            sgl = ov;
            dbl = (!ov) && (syn != 0);
            // odd overall parity: flip the bit the syndrome names
            if (ov && (syn < N)) begin
                c[syn] = ~c[syn];
            end
            j = 0;
            for (i = 1; i < N; i = i + 1) begin
                if ((i & (i - 1)) != 0) begin
                    d[j] = c[i];
                    j = j + 1;
                end
            end
            ecc_decode = {dbl, sgl, d};
        end
    endfunction

    // handshake terms, full and empty from the occupancy
    // ready and valid are combinational from registers only,
    // so a partner that honours them never sees a refusal;
    // a partner that ignores them gets the refusal pulse and
    // the fifo keeps its contents and pointers untouched
    // when full, a write is refused even with a read taken
    assign full         = (count_reg == DEPTH[CW-1:0]);
    assign empty        = (count_reg == {CW{1'b0}});
    assign WR_READY_OUT = !full;
    assign RD_VALID_OUT = !empty;
    assign wr_take      = WR_REQ_IN && !full;
    assign rd_take      = RD_REQ_IN && !empty;
    assign dec_rd       = ecc_decode(mem_reg[rd_ptr_reg]);

    // codeword for the write, with optional fault injection
    // injection only matters with an accepted write, since
    // storage is written on wr_take alone
    // double wins over single when both are raised
    // without error correction the clean codeword is stored
    always @* begin
        code_w = ecc_encode(WR_DATA_IN);
        if (ECC_EN != 0) begin
            if (DOUBLE_ERROR_INJECT_IN) begin
                // two flips: decoder must call it uncorrectable
                code_w[`RAFS_INJ_BIT_A] = ~code_w[`RAFS_INJ_BIT_A]; // R7
                code_w[`RAFS_INJ_BIT_B] = ~code_w[`RAFS_INJ_BIT_B]; // R7
            end else if (SINGLE_ERROR_INJECT_IN) begin
                code_w[`RAFS_INJ_BIT_A] = ~code_w[`RAFS_INJ_BIT_A]; // R6
            end
        end
    end

    // occupancy after this edge
    // read and write in one cycle cancel out
    // refused requests leave the count as it is
    // count_next feeds tallies and level flags so that
    // they all move at the edge that takes the transfer
    always @* begin
        count_next = count_reg;
        if (wr_take && !rd_take) begin
            count_next = count_reg + ONE_WORD;
        end else if (rd_take && !wr_take) begin
            count_next = count_reg - ONE_WORD;
        end
    end

    // storage write, refused writes touch nothing
    // storage is not reset: contents before the first
    // write are unknown and never read, as empty blocks reads
    always @(posedge CLK_SYS_IN) begin
        if (wr_take) begin // R10
            mem_reg[wr_ptr_reg] <= code_w;
        end
    end

    // pointers, occupancy and captured thresholds
    // thresholds follow the inputs on every reset edge;
    // the last edge with reset low wins, and outside reset
    // the inputs are ignored entirely
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            wr_ptr_reg    <= {ADDR_W{1'b0}};
            rd_ptr_reg    <= {ADDR_W{1'b0}};
            count_reg     <= {CW{1'b0}};
            // levels may change while reset is held
            upper_thr_reg <= UPPER_LEVEL_THRESHOLD_IN; // R1 R3
            lower_thr_reg <= LOWER_LEVEL_THRESHOLD_IN; // R2 R3
        end else begin
            // pointers move only on accepted transfers
            if (wr_take) begin // R10
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (rd_take) begin // R12
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
        end
    end

    // read word and its error flags, registered together
    // the flags belong to the word shown and hold with it
    // until the next accepted read
    // an uncorrectable flag marks the shown word as corrupt
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            RD_DATA_OUT                  <= {WIDTH{1'b0}};
            CORRECTED_ERROR_FLAG_OUT     <= `RAFS_RST_FLAG; // R19
            UNCORRECTABLE_ERROR_FLAG_OUT <= `RAFS_RST_FLAG; // R19
        end else if (rd_take) begin
            RD_DATA_OUT <= dec_rd[WIDTH-1:0];
            if (ECC_EN != 0) begin
                CORRECTED_ERROR_FLAG_OUT     <= dec_rd[WIDTH];   // R8
                UNCORRECTABLE_ERROR_FLAG_OUT <= dec_rd[WIDTH+1]; // R9
            end else begin
                CORRECTED_ERROR_FLAG_OUT     <= `RAFS_RST_FLAG;
                UNCORRECTABLE_ERROR_FLAG_OUT <= `RAFS_RST_FLAG;
            end
        end
    end

    // refusal flags, one cycle after the refused request
    // each is a pulse: a refused request repeated every cycle
    // keeps the flag up for as long as it is repeated
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            WRITE_REFUSED_FLAG_OUT <= `RAFS_RST_FLAG; // R19
            READ_REFUSED_FLAG_OUT  <= `RAFS_RST_FLAG; // R19
        end else begin
            // stays low while the master honours ready
            WRITE_REFUSED_FLAG_OUT <= WR_REQ_IN && full;  // R10 R11
            // stays low while the slave honours valid
            READ_REFUSED_FLAG_OUT  <= RD_REQ_IN && empty; // R12 R13
        end
    end

    // tallies, all registered from the next occupancy
    // single clock, so write, read and common tallies all
    // equal the exact occupancy, which neither under reports
    // for the writer nor over reports for the reader
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            WR_WORD_TALLY_OUT     <= {CW{1'b0}}; // R19
            RD_WORD_TALLY_OUT     <= {CW{1'b0}}; // R19
            STORED_WORD_TALLY_OUT <= {CW{1'b0}}; // R19
        end else begin
            // a write lands here at the edge that takes it
            WR_WORD_TALLY_OUT     <= count_next; // R14 R15
            // a read leaves here at the edge that takes it
            RD_WORD_TALLY_OUT     <= count_next; // R16 R17
            STORED_WORD_TALLY_OUT <= count_next; // R18
        end
    end

    // level flags against the captured thresholds
    // thresholds are zero extended to tally width
    // both flags move at the same edge as the tallies, so a
    // flag disagrees with the tally shown beside it only when the upper flag keeps its reset 0 against an upper level of 0
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            UPPER_LEVEL_FLAG_OUT <= `RAFS_RST_FLAG;     // R19
            LOWER_LEVEL_FLAG_OUT <= `RAFS_RST_LOW_FLAG; // R19
        end else begin
            UPPER_LEVEL_FLAG_OUT <= (count_next >= {2'b00, upper_thr_reg}); // R4
            LOWER_LEVEL_FLAG_OUT <= (count_next <= {2'b00, lower_thr_reg}); // R5
        end
    end

endmodule

`default_nettype wire

/* File: verif/rafs_partner.sv */
// upstream master and downstream slave stand-in
`timescale 1ns/1ns
`default_nettype none
module rafs_partner (
    input  wire logic wr_go_in,   // wants to write
    input  wire logic rd_go_in,   // wants to read
    input  wire logic rude_in,    // ignore the handshake
    input  wire logic ready_in,   // room in fifo
    input  wire logic valid_in,   // word in fifo
    output logic      wr_req_out, // write request
    output logic      rd_req_out  // read request
);
    // requests offered while the fifo can take them, or always when rude_in is set
    assign wr_req_out = wr_go_in && (ready_in || rude_in);
    assign rd_req_out = rd_go_in && (valid_in || rude_in);
endmodule
`default_nettype wire

/* File: verif/rafs_sideband_props.sv */
// checker for the read address fifo sideband block
`timescale 1ns/1ns
`default_nettype none
module rafs_sideband_props #(
    parameter integer DEPTH  = 16, // words
    parameter integer ADDR_W = 4,  // log2 depth
    parameter integer WIDTH  = 32  // payload bits
) (
    input wire logic              CLK_SYS_IN,                   // clock
    input wire logic              RSTN_IN,                      // reset
    input wire logic              WR_REQ_IN,                    // write req
    input wire logic              WR_READY_OUT,                 // room
    input wire logic              RD_REQ_IN,                    // read req
    input wire logic              RD_VALID_OUT,                 // word there
    input wire logic [WIDTH-1:0]  RD_DATA_OUT,                  // payload
    input wire logic              CORRECTED_ERROR_FLAG_OUT,     // fixed
    input wire logic              UNCORRECTABLE_ERROR_FLAG_OUT, // corrupt
    input wire logic              WRITE_REFUSED_FLAG_OUT,       // refused
    input wire logic              READ_REFUSED_FLAG_OUT,        // refused
    input wire logic [ADDR_W+1:0] WR_WORD_TALLY_OUT,            // tally
    input wire logic [ADDR_W+1:0] RD_WORD_TALLY_OUT,            // tally
    input wire logic [ADDR_W+1:0] STORED_WORD_TALLY_OUT,        // tally
    input wire logic [ADDR_W-1:0] UPPER_LEVEL_THRESHOLD_IN,     // upper
    input wire logic [ADDR_W-1:0] LOWER_LEVEL_THRESHOLD_IN,     // lower
    input wire logic              UPPER_LEVEL_FLAG_OUT,         // high flag
    input wire logic              LOWER_LEVEL_FLAG_OUT          // low flag
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);
    logic [ADDR_W-1:0] up_cap_reg; // upper seen in reset
    logic [ADDR_W-1:0] lo_cap_reg; // lower seen in reset
    logic              wr_ok;      // write taken
    logic              rd_ok;      // read taken
    assign wr_ok = WR_REQ_IN && WR_READY_OUT;
    assign rd_ok = RD_REQ_IN && RD_VALID_OUT;
    // thresholds only follow the inputs while reset is held
    always @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
            up_cap_reg <= UPPER_LEVEL_THRESHOLD_IN;
            lo_cap_reg <= LOWER_LEVEL_THRESHOLD_IN;
        end
    end
    a_upper_flag: assert property ($past(RSTN_IN) |->
        UPPER_LEVEL_FLAG_OUT == (STORED_WORD_TALLY_OUT >= up_cap_reg)) else $error("upper flag off");
    a_lower_flag: assert property ($past(RSTN_IN) |->
        LOWER_LEVEL_FLAG_OUT == (STORED_WORD_TALLY_OUT <= lo_cap_reg)) else $error("lower flag off");
    a_wr_refused: assert property (WR_REQ_IN && !WR_READY_OUT |=>
        WRITE_REFUSED_FLAG_OUT &&
        STORED_WORD_TALLY_OUT == $past(STORED_WORD_TALLY_OUT) - $past(rd_ok)) else $error("write refusal");
    a_rd_refused: assert property (RD_REQ_IN && !RD_VALID_OUT |=>
        READ_REFUSED_FLAG_OUT &&
        STORED_WORD_TALLY_OUT == $past(STORED_WORD_TALLY_OUT) + $past(wr_ok)) else $error("read refusal");
    a_wr_tally_step: assert property (wr_ok && !rd_ok |=>
        WR_WORD_TALLY_OUT == $past(WR_WORD_TALLY_OUT) + 1) else $error("write tally step");
    a_rd_tally_step: assert property (rd_ok && !wr_ok |=>
        RD_WORD_TALLY_OUT == $past(RD_WORD_TALLY_OUT) - 1) else $error("read tally step");
    a_tallies_agree: assert property (WR_WORD_TALLY_OUT == STORED_WORD_TALLY_OUT &&
        RD_WORD_TALLY_OUT == STORED_WORD_TALLY_OUT) else $error("tallies differ");
    a_hs_level: assert property (WR_READY_OUT == (STORED_WORD_TALLY_OUT < DEPTH) &&
        RD_VALID_OUT == (STORED_WORD_TALLY_OUT != 0)) else $error("handshake vs tally");
    a_err_hold: assert property (!rd_ok |=> $stable(RD_DATA_OUT) &&
        $stable(CORRECTED_ERROR_FLAG_OUT) && $stable(UNCORRECTABLE_ERROR_FLAG_OUT)) else $error("read side moved");
    c_wr_refused: cover property (WRITE_REFUSED_FLAG_OUT);
    c_corrected: cover property (CORRECTED_ERROR_FLAG_OUT);
    c_uncorrectable: cover property (UNCORRECTABLE_ERROR_FLAG_OUT);
endmodule
`default_nettype wire

/* File: verif/rafs_sideband_tb_top.sv */
// testbench for the read address fifo sideband block
`timescale 1ns/1ns
`default_nettype none
module rafs_sideband_tb_top;
    logic        clk = 1'b0;      // system clock
    logic        rstn = 1'b0;     // reset, low
    logic [4:0]  cmd = 5'h00;     // write, read, rude, single, double
    logic [31:0] wr_data = 32'h0; // payload
    logic [3:0]  up_thr = 4'h0;   // upper threshold
    logic [3:0]  lo_thr = 4'h0;   // lower threshold
    logic        wr_req, rd_req, ready, valid, corr, unc, wref, rref, upf, lof;
    logic [31:0] rd_data;         // read payload
    logic [5:0]  wt, rt, st;      // tallies
    int          mismatches = 0;
    int          n_checks = 0;
    always #10 clk = ~clk;
    rafs_partner u_partner (.wr_go_in(cmd[4]), .rd_go_in(cmd[3]), .rude_in(cmd[2]),
        .ready_in(ready), .valid_in(valid), .wr_req_out(wr_req), .rd_req_out(rd_req));
    rafs_sideband u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .WR_REQ_IN(wr_req), .WR_DATA_IN(wr_data),
        .WR_READY_OUT(ready), .RD_REQ_IN(rd_req), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(valid),
        .UPPER_LEVEL_THRESHOLD_IN(up_thr), .LOWER_LEVEL_THRESHOLD_IN(lo_thr),
        .SINGLE_ERROR_INJECT_IN(cmd[1]), .DOUBLE_ERROR_INJECT_IN(cmd[0]),
        .CORRECTED_ERROR_FLAG_OUT(corr), .UNCORRECTABLE_ERROR_FLAG_OUT(unc),
        .WRITE_REFUSED_FLAG_OUT(wref), .READ_REFUSED_FLAG_OUT(rref), .WR_WORD_TALLY_OUT(wt),
        .RD_WORD_TALLY_OUT(rt), .STORED_WORD_TALLY_OUT(st), .UPPER_LEVEL_FLAG_OUT(upf),
        .LOWER_LEVEL_FLAG_OUT(lof));
    // counts a comparison and reports a miss
    task chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // one request for one cycle, results settled on return
    task op(input logic [4:0] c, input logic [31:0] d);
        @(posedge clk);
        cmd <= c;
        wr_data <= d;
        @(posedge clk);
        cmd <= 5'h00;
        #1;
    endtask
    // reset with thresholds, then scramble them
    task rst(input logic [3:0] u, input logic [3:0] l);
        @(posedge clk);
        rstn <= 1'b0;
        up_thr <= u;
        lo_thr <= l;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        up_thr <= ~u;
        lo_thr <= ~l;
        #1;
        chk(st === 6'h00 && wt === 6'h00 && rt === 6'h00 && upf === 1'b0 && lof === 1'b1, "reset tally");
        chk(corr === 1'b0 && unc === 1'b0 && wref === 1'b0 && rref === 1'b0, "reset flags");
    endtask
    // tallies and level flags against the expected occupancy
    task lvl(input logic [5:0] k, input int u, input int l);
        chk(st === k && wt === k && rt === k, "tally");
        chk(upf === (k >= u), "upper flag");
        chk(lof === (k <= l), "lower flag");
    endtask
    // fill n words, refuse when full if n is 16, drain, refuse when empty
    task run(input int n, input int u, input int l);
        for (int i = 0; i < n; i++) begin
            op(5'h10, 32'hC0DE0000 + i);
            lvl(i + 1, u, l);
        end
        if (n == 16) begin
            op(5'h14, 32'hDEADBEEF);
            chk(wref === 1'b1 && st === 6'h10, "write refusal");
            @(posedge clk);
            #1;
            chk(wref === 1'b0, "refusal pulse");
        end
        for (int i = 0; i < n; i++) begin
            op(5'h08, 32'h0);
            chk(rd_data === 32'hC0DE0000 + i && corr === 1'b0 && unc === 1'b0, "read word");
            lvl(n - 1 - i, u, l);
        end
        op(5'h0C, 32'h0);
        chk(rref === 1'b1 && st === 6'h00 && valid === 1'b0, "read refusal");
    endtask
    // injected errors show up on the read side
    task ecc;
        op(5'h12, 32'h1234ABCD);
        op(5'h11, 32'h55AA33CC);
        op(5'h10, 32'h0F0F0F0F);
        op(5'h08, 32'h0);
        chk(rd_data === 32'h1234ABCD && corr === 1'b1 && unc === 1'b0, "single fix");
        op(5'h08, 32'h0);
        chk(unc === 1'b1 && corr === 1'b0, "double flag");
        op(5'h08, 32'h0);
        chk(rd_data === 32'h0F0F0F0F && corr === 1'b0 && unc === 1'b0, "clean word");
    endtask
    // write and read in one cycle leave the tally alone
    task both;
        op(5'h10, 32'hA5A50001);
        op(5'h18, 32'hA5A50002);
        chk(rd_data === 32'hA5A50001 && st === 6'h01, "read with write");
        op(5'h08, 32'h0);
        chk(rd_data === 32'hA5A50002 && st === 6'h00, "second word");
    endtask
    // closing report
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst(4'hC, 4'h3);
        run(16, 12, 3);
        $display("test fill_drain done");
        ecc;
        $display("test ecc done");
        both;
        $display("test both done");
        rst(4'h2, 4'h4);
        run(5, 2, 4);
        $display("test thresholds done");
        print_verdict;
    end
endmodule
bind rafs_sideband rafs_sideband_props #(.DEPTH(DEPTH), .ADDR_W(ADDR_W), .WIDTH(WIDTH)) u_props (.*);
`default_nettype wire
